/* File: include/identity_pkg.sv */
// Package with command codes, field layouts and carriers for the identity store
package identity_pkg;
    // Command codes of the identity fields
    localparam logic [7:0] CMD_MANUFACTURER_ID = 8'h99;
    localparam logic [7:0] CMD_MANUFACTURER_MODEL = 8'h9A;
    localparam logic [7:0] CMD_MANUFACTURER_REVISION = 8'h9B;
    localparam logic [7:0] CMD_SERIAL_NUMBER = 8'h9E;
    localparam logic [7:0] CMD_DEVICE_TYPE = 8'hAD;
    // Field sizes in bytes, also the block byte count
    localparam logic [7:0] FIELD_BYTES = 8'h03;
    localparam logic [7:0] DEVICE_TYPE_BYTES = 8'h06;
    localparam int FIELD_WIDTH = 24;
    localparam int DEVICE_TYPE_WIDTH = 48;
    localparam int FIELD_COUNT = 4;
    // Field slots; slots 0 to 3 lie inside the store image
    localparam logic [2:0] SLOT_ID = 3'h0;
    localparam logic [2:0] SLOT_MODEL = 3'h1;
    localparam logic [2:0] SLOT_REVISION = 3'h2;
    localparam logic [2:0] SLOT_SERIAL = 3'h3;
    localparam logic [2:0] SLOT_DEVICE_TYPE = 3'h4;
    localparam logic [2:0] SLOT_NONE = 3'h7;
    // Reset values and filler
    localparam logic [FIELD_WIDTH-1:0] FIELD_RESET = 24'h000000;
    localparam logic [7:0] READ_PAST_END = 8'hFF;
    // Status bit positions
    localparam int INVALID_COMMAND_BIT = 7;
    localparam int COMM_FAULT_BIT = 1;
    // Checksum
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

    // Four writable identity fields
    typedef logic [FIELD_COUNT-1:0][FIELD_WIDTH-1:0] store_image_t;

    // Transaction opening from the protocol engine
    typedef struct packed {
        logic [7:0] code;
        logic write;
    } cmd_req_t;

    // Byte stream strobe with data
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;
endpackage

/* File: rtl/store_checksum.sv */
// Checksum over the nonvolatile identity store image
`timescale 1ns/1ps
module store_checksum
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire identity_pkg::store_image_t image,
    output logic [31:0] checksum
);
    import identity_pkg::*;

    // Registered checksum state
    typedef struct packed {
        logic [31:0] sum;
    } sum_state_t;

    sum_state_t st;
    sum_state_t next_st;

    // CRC over all twelve bytes; linear, so a 24-bit change always shows
    function automatic logic [31:0] crc_image(input store_image_t img);
        logic [31:0] c;
        logic [FIELD_COUNT*FIELD_WIDTH-1:0] flat;
        c = CRC_INIT;
        flat = img;
        for (int i = 0; i < FIELD_COUNT * FIELD_WIDTH; i++)
        begin
            c = c[31] ^ flat[i] ? ({c[30:0], 1'b0} ^ CRC_POLY) : {c[30:0], 1'b0};
        end
        return c;
    endfunction

    // Next checksum
    always_comb
    begin
        next_st.sum = crc_image(image);
    end

    // Checksum register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign checksum = st.sum;
endmodule

/* File: rtl/pmbus_identity_registers.sv */
// Identity field store behind the block read and block write commands
`timescale 1ns/1ps
module pmbus_identity_registers
#(
    // Arbitrary value, not any real part's code
    parameter logic [47:0] DEVICE_TYPE_VALUE = 48'h0000_0000_0001
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire identity_pkg::cmd_req_t cmd_req,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire identity_pkg::byte_beat_t write_beat,
    input wire logic read_req,
    output identity_pkg::byte_beat_t read_beat,
    output logic cmd_hit,
    input wire logic nvm_load,
    input wire identity_pkg::store_image_t nvm_image,
    output identity_pkg::store_image_t store_image,
    output logic [31:0] nonvolatile_checksum,
    input wire logic clear_faults,
    output logic communication_fault_bit,
    output logic invalid_command_flag,
    output logic host_alert
);
    import identity_pkg::*;

    // Whole block state
    typedef struct packed {
        store_image_t fields;        // Identity fields
        logic active;                // Transaction open
        logic write;                 // Open transaction is a write
        logic [2:0] slot;            // Addressed field
        logic [2:0] index;           // Byte position, 0 = count
        logic [7:0] count;           // Byte count the host sent
        logic [FIELD_WIDTH-1:0] buf_data; // Incoming field bytes
        byte_beat_t rd;              // Outgoing byte
        logic comm_fault;            // Summary communication bit
        logic ivc;                   // Invalid command flag
    } state_t;

    state_t st;
    state_t next_st;
    logic [2:0] req_slot;
    logic [DEVICE_TYPE_WIDTH-1:0] read_word;
    logic [7:0] read_len;
    logic commit;
    logic bad_write;

    // Command code to field slot
    function automatic logic [2:0] slot_of(input logic [7:0] code);
        unique case (code)
            CMD_MANUFACTURER_ID: return SLOT_ID;
            CMD_MANUFACTURER_MODEL: return SLOT_MODEL;
            CMD_MANUFACTURER_REVISION: return SLOT_REVISION;
            CMD_SERIAL_NUMBER: return SLOT_SERIAL;
            CMD_DEVICE_TYPE: return SLOT_DEVICE_TYPE;
            default: return SLOT_NONE;
        endcase
    endfunction

    // Decode of the opening command
    assign req_slot = slot_of(cmd_req.code);
    assign cmd_hit = cmd_start && (req_slot != SLOT_NONE);
    assign bad_write = cmd_start && cmd_req.write && (req_slot == SLOT_DEVICE_TYPE);

    // Source of read data for the open transaction
    always_comb
    begin
        if (st.slot == SLOT_DEVICE_TYPE)
        begin
            read_word = DEVICE_TYPE_VALUE;
            read_len = DEVICE_TYPE_BYTES;
        end
        else if (st.slot < SLOT_DEVICE_TYPE)
        begin
            read_word = {24'h000000, st.fields[st.slot[1:0]]};
            read_len = FIELD_BYTES;
        end
        else
        begin
            read_word = '0;
            read_len = 8'h00;
        end
    end

    // A write lands only with the right count and exactly three data bytes
    assign commit = cmd_stop && st.active && st.write && (st.slot < SLOT_DEVICE_TYPE)
        && (st.count == FIELD_BYTES) && (st.index == 3'h4);

    // Next state
    always_comb
    begin
        next_st = st;
        next_st.rd.valid = 1'b0;
        // New transaction opens and drops any half-done one
        if (cmd_start)
        begin
            next_st.active = (req_slot != SLOT_NONE) && !bad_write;
            next_st.write = cmd_req.write;
            next_st.slot = req_slot;
            next_st.index = 3'h0;
            next_st.count = 8'h00;
            next_st.buf_data = '0;
        end
        else if (st.active && st.write && write_beat.valid)
        begin
            // First byte is the count, then LSB first
            if (st.index == 3'h0)
                next_st.count = write_beat.data;
            else if (st.index <= 3'h3)
                next_st.buf_data[(st.index - 3'h1) * 8 +: 8] = write_beat.data;
            if (st.index != 3'h7)
                next_st.index = st.index + 3'h1;
        end
        else if (st.active && !st.write && read_req)
        begin
            // Count first, then bytes from the low end, filler past the end
            next_st.rd.valid = 1'b1;
            if (st.index == 3'h0)
                next_st.rd.data = read_len;
            else if ({5'h00, st.index} <= read_len)
                next_st.rd.data = read_word[(st.index - 3'h1) * 8 +: 8];
            else
                next_st.rd.data = READ_PAST_END;
            if (st.index != 3'h7)
                next_st.index = st.index + 3'h1;
        end
        // Host write to a writable field; no wear guard, software writes sparingly
        if (commit)
            next_st.fields[st.slot[1:0]] = st.buf_data;
        if (cmd_stop)
            next_st.active = 1'b0;
        // Reload from the nonvolatile store takes priority over a host write
        if (nvm_load)
            next_st.fields = nvm_image;
        // Fault flags: a new fault wins over a clear in the same cycle
        if (clear_faults)
        begin
            next_st.comm_fault = 1'b0;
            next_st.ivc = 1'b0;
        end
        if (bad_write)
        begin
            next_st.comm_fault = 1'b1;
            next_st.ivc = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= '0;
            st.slot <= SLOT_NONE;
            st.fields <= {FIELD_COUNT{FIELD_RESET}};
        end
        else
            st <= next_st;
    end

    // Checksum over the store image, serial included
    store_checksum u_checksum
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .image(st.fields),
        .checksum(nonvolatile_checksum)
    );

    // Outputs from state
    assign read_beat = st.rd;
    assign store_image = st.fields;
    assign communication_fault_bit = st.comm_fault;
    assign invalid_command_flag = st.ivc;
    assign host_alert = st.comm_fault; // Level alert while the fault stands

    // Helper: a commit with no reload from the store in the same cycle
    sequence commit_seen;
        commit && !nvm_load;
    endsequence

    // Helper: write to the type code opens
    sequence type_write_open;
        cmd_start && cmd_req.write && cmd_req.code == CMD_DEVICE_TYPE;
    endsequence

    ident_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        commit_seen and (st.slot == SLOT_ID) |=> st.fields[0] == $past(st.buf_data))
        else $error("identifier write not stored");
    model_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        commit_seen and (st.slot == SLOT_MODEL) |=> st.fields[1] == $past(st.buf_data))
        else $error("model write not stored");
    revision_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        commit_seen and (st.slot == SLOT_REVISION) |=> st.fields[2] == $past(st.buf_data))
        else $error("revision write not stored");
    serial_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        commit_seen and (st.slot == SLOT_SERIAL) |=> st.fields[3] == $past(st.buf_data))
        else $error("serial write not stored");
    // Checksum register follows the fields one cycle later, so it moves on the next edge
    serial_checksum_a: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(st.fields[3]) && $stable(st.fields[2:0]) |=>
        nonvolatile_checksum != $past(nonvolatile_checksum))
        else $error("serial change left checksum unchanged");
    type_fixed_a: assert property (@(posedge clk_sys) disable iff (rst)
        type_write_open |=> !st.active ##1 $stable(st.fields))
        else $error("type code write was accepted");
    ivc_raise_a: assert property (@(posedge clk_sys) disable iff (rst)
        type_write_open |=> invalid_command_flag && communication_fault_bit && host_alert)
        else $error("invalid command fault not raised");
    count_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        st.active && !st.write && read_req && !cmd_start && !cmd_stop && st.index == 3'h0
        |=> read_beat.valid && read_beat.data == $past(read_len))
        else $error("block read did not start with byte count");
endmodule

/* File: bench/host_model.sv */
// Host controller model issuing block writes and block reads
`timescale 1ns/1ps
module host_model
(
    input wire logic clk_sys,
    output identity_pkg::cmd_req_t cmd_req,
    output logic cmd_start,
    output logic cmd_stop,
    output identity_pkg::byte_beat_t write_beat,
    output logic read_req,
    input wire identity_pkg::byte_beat_t read_beat
);
    import identity_pkg::*;
    // Idle until a task drives a transfer
    initial
    begin
        cmd_req = '0;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        write_beat = '0;
        read_req = 1'b0;
    end
    // Start strobe for one cycle; code scrambled once released
    task automatic open_cmd(input logic [7:0] code, input logic wr);
        @(posedge clk_sys) #1;
        cmd_req = '{code: code, write: wr};
        cmd_start = 1'b1;
        @(posedge clk_sys) #1;
        cmd_start = 1'b0;
        cmd_req = ~cmd_req;
    endtask
    // Ends a transaction with a one-cycle stop strobe
    task automatic close_cmd();
        cmd_stop = 1'b1;
        @(posedge clk_sys) #1;
        cmd_stop = 1'b0;
    endtask
    // Count byte, then data least significant byte first
    task automatic block_write(input logic [7:0] code, input logic [7:0] cnt,
        input logic [23:0] val);
        open_cmd(code, 1'b1);
        write_beat = '{valid: 1'b1, data: cnt};
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_sys) #1;
            write_beat = '{valid: 1'b1, data: val[8*i+:8]};
        end
        @(posedge clk_sys) #1;
        write_beat = '{valid: 1'b0, data: ~write_beat.data};
        close_cmd();
    endtask
    // One read request per beat; slow adds idle cycles between them
    task automatic block_read(input logic [7:0] code, input int n, input int slow,
        output logic [55:0] got);
        got = '1;
        open_cmd(code, 1'b0);
        for (int k = 0; k < n; k++)
        begin
            read_req = 1'b1;
            @(posedge clk_sys) #1;
            read_req = 1'b0;
            // A missing valid strobe poisons the byte
            got[8*k+:8] = (read_beat.valid === 1'b1) ? read_beat.data : 8'hXX;
            repeat (slow + 1) @(posedge clk_sys);
            #1;
        end
        close_cmd();
    endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the identity field store
`timescale 1ns/1ps
module testbench;
    import identity_pkg::*;
    // Arbitrary type code, not any real part's value
    localparam logic [47:0] DEV_CODE = 48'h0A1B2C3D4E5F;
    localparam logic [95:0] NVM_VAL = 96'h0C0B0A_090807_060504_030201;
    logic clk_sys, rst, cmd_start, cmd_stop, read_req, cmd_hit, hit_seen;
    logic nvm_load, clear_faults, communication_fault_bit, invalid_command_flag, host_alert;
    cmd_req_t cmd_req;
    byte_beat_t write_beat, read_beat;
    store_image_t nvm_image, store_image;
    logic [31:0] nonvolatile_checksum;
    int bad_count = 0;
    int checks_done = 0;
    host_model host_model_i (.clk_sys(clk_sys), .cmd_req(cmd_req), .cmd_start(cmd_start),
        .cmd_stop(cmd_stop), .write_beat(write_beat), .read_req(read_req),
        .read_beat(read_beat));
    pmbus_identity_registers #(.DEVICE_TYPE_VALUE(DEV_CODE)) pmbus_identity_registers_i (
        .clk_sys(clk_sys), .rst(rst), .cmd_req(cmd_req), .cmd_start(cmd_start),
        .cmd_stop(cmd_stop), .write_beat(write_beat), .read_req(read_req),
        .read_beat(read_beat), .cmd_hit(cmd_hit), .nvm_load(nvm_load),
        .nvm_image(nvm_image), .store_image(store_image),
        .nonvolatile_checksum(nonvolatile_checksum), .clear_faults(clear_faults),
        .communication_fault_bit(communication_fault_bit),
        .invalid_command_flag(invalid_command_flag), .host_alert(host_alert));
    // Latch the decode answer of each start cycle
    always @(posedge clk_sys)
        if (cmd_start)
            hit_seen <= cmd_hit;
    // Compare any value up to the image width
    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Reset state, then reload of all fields from the store
    task automatic t_load();
        check(store_image, '0);
        check({communication_fault_bit, invalid_command_flag, host_alert}, 3'h0);
        @(posedge clk_sys) #1;
        nvm_image = NVM_VAL;
        nvm_load = 1'b1;
        @(posedge clk_sys) #1;
        nvm_load = 1'b0;
        check(store_image, NVM_VAL);
    endtask
    // Each field written once, then read back, fast and slow host speeds in turn
    task automatic t_fields();
        logic [7:0] codes [4] = '{8'h99, 8'h9A, 8'h9B, 8'h9E};
        logic [23:0] vals [4] = '{24'h123456, 24'hA5C3E1, 24'h00FF01, 24'hFEDCBA};
        logic [55:0] got;
        for (int i = 0; i < 4; i++)
        begin
            host_model_i.block_write(codes[i], FIELD_BYTES, vals[i]);
            check(hit_seen, 1'b1);
            check(store_image[i], vals[i]);
            host_model_i.block_read(codes[i], 4, i % 2, got);
            check(got[31:0], {vals[i], 8'h03});
        end
    endtask
    // Past-end read, short count and unknown code
    task automatic t_edges();
        logic [55:0] got;
        host_model_i.block_read(8'h99, 5, 0, got);
        check(got[39:32], 8'hFF);
        host_model_i.block_write(8'h9A, 8'h02, 24'h777777);
        check(store_image[1], 24'hA5C3E1);
        host_model_i.block_write(8'h55, FIELD_BYTES, 24'h777777);
        check(hit_seen, 1'b0);
    endtask
    // Fixed type code, refused write, then fault clear
    task automatic t_device();
        logic [55:0] got;
        host_model_i.block_read(8'hAD, 7, 1, got);
        check(got, {DEV_CODE, 8'h06});
        host_model_i.block_write(8'hAD, FIELD_BYTES, 24'h111111);
        check({communication_fault_bit, invalid_command_flag, host_alert}, 3'h7);
        check(store_image[0], 24'h123456);
        clear_faults = 1'b1;
        @(posedge clk_sys) #1;
        clear_faults = 1'b0;
        @(posedge clk_sys) #1;
        check({communication_fault_bit, invalid_command_flag, host_alert}, 3'h0);
        // Refused write in the very cycle of a clear: the new fault must win
        fork
            host_model_i.open_cmd(8'hAD, 1'b1);
            begin
                @(posedge clk_sys) #1;
                clear_faults = 1'b1;
                @(posedge clk_sys) #1;
                clear_faults = 1'b0;
            end
        join
        host_model_i.close_cmd();
        check({communication_fault_bit, invalid_command_flag, host_alert}, 3'h7);
    endtask
    // Serial value must move the checksum and restore it when put back
    task automatic t_checksum();
        logic [31:0] first;
        first = nonvolatile_checksum;
        host_model_i.block_write(8'h9E, FIELD_BYTES, 24'hFEDCBB);
        @(posedge clk_sys) #1;
        check(nonvolatile_checksum !== first, 1'b1);
        host_model_i.block_write(8'h9E, FIELD_BYTES, 24'hFEDCBA);
        @(posedge clk_sys) #1;
        check(nonvolatile_checksum, first);
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        nvm_load = 1'b0;
        nvm_image = '0;
        clear_faults = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_load();
        t_fields();
        t_edges();
        t_device();
        t_checksum();
        conclude();
    end
    // Hang guard, far beyond the under two hundred cycles needed
    initial
    begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule
